// *** logic/ebc_cfg_map.vh ***
// Register map, field positions and codes of the external bus configuration block
`ifndef EBC_CFG_MAP_VH
`define EBC_CFG_MAP_VH

`define OFF_SCR        12'h000
`define OFF_IPTR       12'h004
`define OFF_CSEG       12'h008

`define WS_MSB         3
`define WS_LSB         0
`define BT_MSB         7
`define BT_LSB         6
`define BSD_BIT        8
`define SGD_BIT        9
`define ROM_BIT        10
`define WS_RST         4'hF

`define BT_SINGLE      2'h0
`define BT_MUX8        2'h1
`define BT_MUX16       2'h2
`define BT_DEMUX       2'h3

`define SEG_ZERO       2'h0
`define INT_LO         16'hFA00
`define ROM_HI         16'h1FFF
`define STEP_ONE       18'h00001
`define CNT_ZERO       4'h0
`define CNT_ONE        4'h1

`define ST_IDLE        2'h0
`define ST_ADDR        2'h1
`define ST_DATA        2'h2

`endif

// *** logic/ext_bus_cfg.v ***
// External bus configuration, address steering and bus sequencer with APB registers
// Functional notes
// R1: Config pins captured at reset into bus type field, pin1 bit 7, pin0 bit 6.
// R2: Bus type 00 single-chip, 01 mux 8-bit, 10 mux 16-bit, 11 non-mux 16-bit.
// R3: Mux modes use port 0 for address/data; non-mux port 1 address; port 4 segment.
// R4: After reset the pins are ignored; only the stored field steers the bus.
// R5: Bus type field writable only if single-chip was chosen at reset.
// R6: ROM enable set at reset only for single-chip mode; read-only for software.
// R7: Port 4 carries segment bits in bus modes until segmentation disable is set.
// R8: Byte-high select enabled in 16-bit modes until byte select disable is set.
// R9: Reset puts bus timing at its slowest setting.
// R10: Addresses 0FA00h to 0FFFFh always served internally.
// R11: First 8 Kbytes internal only with single-chip ROM enable, else external.
// R12: 02000h to 0F9FFh and nonzero segments go to the external bus.
// R13: Non-segmented or single-chip mode limits addresses to 16 bits.
// R14: External access attempt in single-chip mode raises a trap, no bus cycle.
// R15: Reset clears instruction pointer and code segment pointer.
// R16: 8-bit mode splits word access into low then high byte at next address.
// R17: Mux modes pulse the address latch strobe with address on port 0.
// R18: Leaving single-chip mode adds external memory, on-chip stays reachable.
// R19: Port 1 free in 8-bit mux mode; ports 0, 1, 4 free in single-chip.
// R20: Segmentation disabled means 16-bit addresses.
// R21: Select/A0: 00 word, 01 high byte, 10 low byte.
// R22: Byte writes on 16-bit bus drive the byte on both halves.
// R23: Bus type change applies from the next access, not one in progress.
`timescale 1ns/10ps
`include "ebc_cfg_map.vh"

module ext_bus_cfg (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        bus_cfg_pin_0,
    input  wire        bus_cfg_pin_1,
    input  wire        req,
    input  wire [17:0] req_addr,
    input  wire        req_wr,
    input  wire        req_word,
    input  wire [15:0] req_wdata,
    output reg         ack_q,
    output reg         int_sel_q,
    output reg         trap_q,
    output reg  [15:0] rdata_q,
    output reg  [15:0] instruction_pointer,
    output reg  [1:0]  code_segment_pointer,
    input  wire [15:0] port0_in,
    output reg  [15:0] port0_out_q,
    output reg         port0_oe_lo_n_q,
    output reg         port0_oe_hi_n_q,
    output reg  [15:0] port1_out_q,
    output reg  [1:0]  port4_out_q,
    output reg         port0_bus_q,
    output reg         port1_bus_q,
    output reg         port4_bus_q,
    output reg         ale_q,
    output reg         rd_n_q,
    output reg         wr_n_q,
    output reg         upper_byte_select_n
);

    reg        cfg0_s1, cfg0_s2, cfg1_s1, cfg1_s2;
    reg [15:0] p0_s1, p0_s2;
    reg        cfg_done_q;
    reg [1:0]  bus_type_field;
    reg        locked_q;
    reg        internal_rom_enable;
    reg        segmentation_disable;
    reg        byte_select_disable;
    reg [3:0]  wait_q;
    reg [1:0]  state_q;
    reg [1:0]  mode_q;
    reg [17:0] addr_q;
    reg        wr_q;
    reg        word_q;
    reg        half_q;
    reg        bhe_en_q;
    reg [15:0] wdata_q;
    reg [3:0]  cnt_q;

    wire [31:0] scr_val;
    wire        seg_en;
    wire [17:0] eff_addr;
    wire        acc_edge;
    wire        wr_edge;
    wire        setup;
    wire        mapped;
    wire        last_wait;
    wire [7:0]  cur_byte;

    // Internal decode shared by start of access
    function is_internal;
        input [17:0] a;
        input        rom;
        begin
            is_internal = (a[17:16] == `SEG_ZERO) &&
                          ((a[15:0] >= `INT_LO) || (rom && a[15:0] <= `ROM_HI)); // R10 R11 R12
        end
    endfunction

    assign scr_val = {21'h0, internal_rom_enable, segmentation_disable, byte_select_disable,
                      bus_type_field, 2'h0, wait_q};
    assign seg_en = (bus_type_field != `BT_SINGLE) && !segmentation_disable; // R20
    assign eff_addr = seg_en ? req_addr : {2'h0, req_addr[15:0]}; // R13
    assign setup = psel && !penable;
    assign acc_edge = psel && penable && pready;
    assign wr_edge = acc_edge && pwrite && !pslverr;
    assign mapped = (paddr == `OFF_SCR) || (paddr == `OFF_IPTR) || (paddr == `OFF_CSEG);
    assign last_wait = (cnt_q == `CNT_ZERO);
    assign cur_byte = half_q ? wdata_q[15:8] : wdata_q[7:0];

    // Pin synchronisers run through reset so the straps are settled at release
    always @(posedge pclk) begin
        cfg0_s1 <= bus_cfg_pin_0;
        cfg0_s2 <= cfg0_s1;
        cfg1_s1 <= bus_cfg_pin_1;
        cfg1_s2 <= cfg1_s1;
        p0_s1   <= port0_in;
        p0_s2   <= p0_s1;
    end

    // Configuration and APB register file
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_done_q           <= 1'b0;
            bus_type_field       <= `BT_SINGLE;
            locked_q             <= 1'b0;
            internal_rom_enable  <= 1'b0;
            segmentation_disable <= 1'b0;
            byte_select_disable  <= 1'b0;
            wait_q               <= `WS_RST; // R9
            instruction_pointer  <= 16'h0000; // R15
            code_segment_pointer <= 2'h0; // R15
            prdata               <= 32'h00000000;
            pready               <= 1'b0;
            pslverr              <= 1'b0;
        end else begin
            if (!cfg_done_q) begin
                // Strap caught once at the first edge after release
                cfg_done_q          <= 1'b1;
                bus_type_field      <= {cfg1_s2, cfg0_s2}; // R1 R2
                internal_rom_enable <= ({cfg1_s2, cfg0_s2} == `BT_SINGLE); // R6
                locked_q            <= ({cfg1_s2, cfg0_s2} != `BT_SINGLE); // R5
            end
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup) begin
                case (paddr)
                    `OFF_SCR:  prdata <= scr_val;
                    `OFF_IPTR: prdata <= {16'h0000, instruction_pointer};
                    `OFF_CSEG: prdata <= {30'h0, code_segment_pointer};
                    default:   prdata <= 32'h00000000;
                endcase
            end
            if (wr_edge && cfg_done_q) begin
                case (paddr)
                    `OFF_SCR: begin
                        wait_q               <= pwdata[`WS_MSB:`WS_LSB];
                        byte_select_disable  <= pwdata[`BSD_BIT]; // R8
                        segmentation_disable <= pwdata[`SGD_BIT]; // R7
                        if (!locked_q) begin
                            bus_type_field <= pwdata[`BT_MSB:`BT_LSB]; // R5 R18
                        end
                    end
                    `OFF_IPTR: instruction_pointer <= pwdata[15:0];
                    `OFF_CSEG: code_segment_pointer <= pwdata[1:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Port ownership follows the stored field; port 4 also follows segmentation disable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port0_bus_q <= 1'b0;
            port1_bus_q <= 1'b0;
            port4_bus_q <= 1'b0;
        end else begin
            port0_bus_q <= cfg_done_q && (bus_type_field != `BT_SINGLE); // R3 R4 R19
            port1_bus_q <= cfg_done_q && (bus_type_field == `BT_DEMUX); // R3 R19
            port4_bus_q <= cfg_done_q && seg_en; // R7
        end
    end

    // Access sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q             <= `ST_IDLE;
            mode_q              <= `BT_SINGLE;
            addr_q              <= 18'h00000;
            wr_q                <= 1'b0;
            word_q              <= 1'b0;
            half_q              <= 1'b0;
            bhe_en_q            <= 1'b0;
            wdata_q             <= 16'h0000;
            cnt_q               <= `CNT_ZERO;
            ack_q               <= 1'b0;
            int_sel_q           <= 1'b0;
            trap_q              <= 1'b0;
            rdata_q             <= 16'h0000;
            port0_out_q         <= 16'h0000;
            port0_oe_lo_n_q     <= 1'b1;
            port0_oe_hi_n_q     <= 1'b1;
            port1_out_q         <= 16'h0000;
            port4_out_q         <= 2'h0;
            ale_q               <= 1'b0;
            rd_n_q              <= 1'b1;
            wr_n_q              <= 1'b1;
            upper_byte_select_n <= 1'b1;
        end else begin
            ack_q     <= 1'b0;
            int_sel_q <= 1'b0;
            trap_q    <= 1'b0;
            case (state_q)
                `ST_IDLE: begin
                    if (cfg_done_q && req && !ack_q && !int_sel_q && !trap_q) begin
                        if (is_internal(eff_addr, internal_rom_enable)) begin
                            int_sel_q <= 1'b1; // R10 R11 R18
                        end else if (bus_type_field == `BT_SINGLE) begin
                            trap_q <= 1'b1; // R14
                        end else begin
                            // Mode sampled here so a rewrite cannot upset this cycle
                            mode_q   <= bus_type_field; // R23
                            bhe_en_q <= (bus_type_field != `BT_MUX8) && !byte_select_disable; // R8
                            addr_q   <= eff_addr; // R12
                            wr_q     <= req_wr;
                            word_q   <= req_word;
                            wdata_q  <= req_wdata;
                            half_q   <= 1'b0;
                            rdata_q  <= 16'h0000;
                            state_q  <= `ST_ADDR;
                        end
                    end
                end
                `ST_ADDR: begin
                    ale_q       <= (mode_q != `BT_DEMUX); // R17
                    port4_out_q <= addr_q[17:16]; // R3
                    if (mode_q == `BT_DEMUX) begin
                        port1_out_q <= addr_q[15:0]; // R3
                    end else begin
                        port0_out_q     <= addr_q[15:0]; // R3
                        port0_oe_lo_n_q <= 1'b0;
                        port0_oe_hi_n_q <= 1'b0;
                    end
                    if (bhe_en_q) begin
                        upper_byte_select_n <= !(word_q || addr_q[0]); // R21
                    end else begin
                        upper_byte_select_n <= 1'b1;
                    end
                    cnt_q   <= wait_q;
                    state_q <= `ST_DATA;
                end
                `ST_DATA: begin
                    ale_q  <= 1'b0;
                    rd_n_q <= wr_q;
                    wr_n_q <= !wr_q;
                    if (mode_q == `BT_MUX8) begin
                        // Upper byte keeps address for the whole cycle
                        port0_out_q     <= {addr_q[15:8], cur_byte}; // R16
                        port0_oe_hi_n_q <= 1'b0;
                        port0_oe_lo_n_q <= !wr_q;
                    end else begin
                        if (word_q) begin
                            port0_out_q <= wdata_q;
                        end else begin
                            port0_out_q <= {wdata_q[7:0], wdata_q[7:0]}; // R22
                        end
                        port0_oe_hi_n_q <= !wr_q;
                        port0_oe_lo_n_q <= !wr_q;
                    end
                    if (!last_wait) begin
                        cnt_q <= cnt_q - `CNT_ONE;
                    end else begin
                        rd_n_q          <= 1'b1;
                        wr_n_q          <= 1'b1;
                        port0_oe_lo_n_q <= 1'b1;
                        port0_oe_hi_n_q <= 1'b1;
                        if (!wr_q) begin
                            if (mode_q == `BT_MUX8) begin
                                if (half_q) begin
                                    rdata_q[15:8] <= p0_s2[7:0]; // R16
                                end else begin
                                    rdata_q[7:0] <= p0_s2[7:0];
                                end
                            end else if (word_q) begin
                                rdata_q <= p0_s2;
                            end else begin
                                rdata_q[7:0] <= addr_q[0] ? p0_s2[15:8] : p0_s2[7:0];
                            end
                        end
                        if (mode_q == `BT_MUX8 && word_q && !half_q) begin
                            half_q  <= 1'b1; // R16
                            addr_q  <= addr_q + `STEP_ONE;
                            state_q <= `ST_ADDR;
                        end else begin
                            ack_q               <= 1'b1;
                            upper_byte_select_n <= 1'b1;
                            state_q             <= `ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= `ST_IDLE;
                end
            endcase
        end
    end

endmodule // ext_bus_cfg

// *** tb/ext_bus_cfg_props.sv ***
// Port-level property checker for the external bus configuration block
`timescale 1ns/10ps
module ext_bus_cfg_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ack_q,
    input wire logic int_sel_q,
    input wire logic trap_q,
    input wire logic port0_oe_lo_n_q,
    input wire logic port0_bus_q,
    input wire logic port1_bus_q,
    input wire logic port4_bus_q,
    input wire logic ale_q,
    input wire logic rd_n_q,
    input wire logic wr_n_q,
    input wire logic upper_byte_select_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ale_mux; ale_q |-> !port1_bus_q ##1 !ale_q; endproperty
    a_ale_mux: assert property (p_ale_mux) else $error("ale outside mux mode");
    property p_sc_free; !port0_bus_q |-> !port1_bus_q && !port4_bus_q; endproperty
    a_sc_free: assert property (p_sc_free) else $error("port owned in single chip");
    property p_seg_bus; port4_bus_q |-> port0_bus_q; endproperty
    a_seg_bus: assert property (p_seg_bus) else $error("segment port without bus");
    property p_trap; trap_q |-> !port0_bus_q && rd_n_q && wr_n_q; endproperty
    a_trap: assert property (p_trap) else $error("trap with bus or strobe");
    property p_ube; !upper_byte_select_n |-> port0_bus_q; endproperty
    a_ube: assert property (p_ube) else $error("byte high select without bus");
    property p_wr_drive; !wr_n_q |-> !port0_oe_lo_n_q && rd_n_q; endproperty
    a_wr_drive: assert property (p_wr_drive) else $error("write data not driven");
    property p_rd_rel; !rd_n_q |-> port0_oe_lo_n_q; endproperty
    a_rd_rel: assert property (p_rd_rel) else $error("data lane driven in read");
    property p_ack; ack_q |-> !$past(rd_n_q && wr_n_q) ##1 !ack_q; endproperty
    a_ack: assert property (p_ack) else $error("ack without bus strobe");
    property p_int; int_sel_q |-> !ack_q && !trap_q ##1 !int_sel_q; endproperty
    a_int: assert property (p_int) else $error("internal select not a lone pulse");
    c_trap: cover property (trap_q);
    c_int: cover property (int_sel_q);
    c_ale: cover property (ale_q);
    c_demux: cover property (ack_q && port1_bus_q);
endmodule // ext_bus_cfg_props

bind ext_bus_cfg ext_bus_cfg_props i_props (.*);

// *** tb/ext_mem_model.sv ***
// External byte or word memory with address latch on the far side of the bus
`timescale 1ns/10ps
module ext_mem_model (
    input wire logic        pclk,
    input wire logic        bus8,
    input wire logic [15:0] port0_out_q,
    input wire logic [15:0] port1_out_q,
    input wire logic        port1_bus_q,
    input wire logic        ale_q,
    input wire logic        rd_n_q,
    input wire logic        wr_n_q,
    input wire logic        upper_byte_select_n,
    output logic     [15:0] port0_in
);
    logic [7:0]  mem [0:255];
    logic [15:0] adr_q;
    logic [15:0] idle_q = 16'h5AA5;
    wire  [15:0] adr = port1_bus_q ? port1_out_q : adr_q;
    wire  [7:0]  ev = {adr[7:1], 1'b0};
    always @(posedge pclk) begin
        if (ale_q) adr_q <= port0_out_q;
        // Released bus toggles so a stale value never looks valid
        if (rd_n_q) idle_q <= ~idle_q;
        if (!wr_n_q) begin
            if (bus8) mem[adr[7:0]] <= port0_out_q[7:0];
            else begin
                if (!adr[0]) mem[ev] <= port0_out_q[7:0];
                if (!upper_byte_select_n) mem[ev + 8'h1] <= port0_out_q[15:8];
            end
        end
    end
    assign port0_in = rd_n_q ? idle_q : bus8 ? {idle_q[15:8], mem[adr[7:0]]} :
                      {mem[ev + 8'h1], mem[ev]};
endmodule // ext_mem_model

// *** tb/external_bus_mode_config_test.sv ***
// Self-checking testbench for the external bus configuration block
`timescale 1ns/10ps
`include "ebc_cfg_map.vh"
module external_bus_mode_config_test;
    localparam logic [2:0] K_ACK = 3'h4, K_INT = 3'h2, K_TRP = 3'h1;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req, req_wr, req_word;
    logic bus_cfg_pin_0, bus_cfg_pin_1, ack_q, int_sel_q, trap_q, ale_q, rd_n_q, wr_n_q;
    logic port0_oe_lo_n_q, port0_oe_hi_n_q, port0_bus_q, port1_bus_q, port4_bus_q;
    logic upper_byte_select_n, bus8, ube_on, seg_on;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [17:0] req_addr, a;
    logic [15:0] req_wdata, rdata_q, instruction_pointer, port0_in, port0_out_q, port1_out_q, w;
    logic [1:0]  code_segment_pointer, port4_out_q, nb;
    logic [7:0]  b;
    logic [34:0] e;
    logic [34:0] core_q[$];
    logic [32:0] apb_q[$];
    int          fails, comparisons, m;

    ext_bus_cfg i_dut (.*);
    ext_mem_model i_mem (.*);

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic check(input string s, input logic [34:0] seen, input logic [34:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", s, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic bail;
        fails++;
        summarize();
    endtask

    function automatic logic [31:0] scr(input logic [1:0] bt, input logic rom,
                                        input logic [1:0] dis);
        scr = 32'hF | (32'(rom) << `ROM_BIT) | (32'(dis) << `BSD_BIT) | (32'(bt) << `BT_LSB);
    endfunction

    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, ad, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        {psel, penable} <= 2'b00;
        if (n >= 20) bail();
    endtask

    task automatic rd(input logic [11:0] ad, input logic err, input logic [31:0] ev);
        apb_q.push_back({err, ev});
        apb(1'b0, ad, 32'h0);
    endtask

    // Lets one pulse edge pass before the next request, so req never toggles twice
    task automatic core(input logic [17:0] ad, input logic [2:0] k, input logic wr, wd,
                        input logic [15:0] d = 16'h0, ed = 16'h0, em = 16'h0);
        int n;
        logic lo;
        logic [1:0] sg;
        core_q.push_back({k, ed & em, em});
        {req, req_addr, req_wr, req_word, req_wdata} <= {1'b1, ad, wr, wd, d};
        n = 0;
        lo = 1'b0;
        sg = 2'h0;
        do begin
            @(posedge pclk);
            n++;
            lo |= !upper_byte_select_n;
            if (!rd_n_q || !wr_n_q) sg = port4_out_q;
        end while ((ack_q | int_sel_q | trap_q) !== 1'b1 && n < 60);
        req <= 1'b0;
        if (n >= 60) bail();
        check("cycles", 35'(n), k == K_ACK ? ((bus8 && wd) ? 35'd36 : 35'd19) : 35'd2);
        check("byte high select", 35'(lo), 35'(k == K_ACK && ube_on));
        check("segment out", 35'(sg), 35'((k == K_ACK && seg_on) ? ad[17:16] : 2'h0));
        @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite)
            check("apb read", 35'({pslverr, prdata}), 35'(apb_q.pop_front()));
        if (ack_q || int_sel_q || trap_q) begin
            e = core_q.pop_front();
            check("core", {ack_q, int_sel_q, trap_q, rdata_q & e[15:0], e[15:0]}, e);
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, req, req_addr, req_wr, req_word} = '0;
        {req_wdata, bus_cfg_pin_1, bus_cfg_pin_0, bus8, ube_on} = '0;
        fails = 0;
        comparisons = 0;
        r = $urandom(68);
        for (m = 0; m < 4; m++) begin
            {bus_cfg_pin_1, bus_cfg_pin_0, bus8} <= {m[1:0], m == 1};
            ube_on = m[1];
            seg_on = (m != 0);
            repeat (3) @(posedge pclk);
            presetn <= 1'b0;
            repeat (2) @(posedge pclk);
            presetn <= 1'b1;
            repeat (2) @(posedge pclk);
            // Straps flipped after release must have no effect
            {bus_cfg_pin_1, bus_cfg_pin_0} <= ~m[1:0];
            rd(`OFF_SCR, 1'b0, scr(m[1:0], m == 0, 2'h0));
            rd(`OFF_IPTR, 1'b0, 32'h0);
            rd(`OFF_CSEG, 1'b0, 32'h0);
            check("port use", 35'({port0_bus_q, port1_bus_q, port4_bus_q}),
                  35'({m != 0, m == 3, m != 0}));
            r = $urandom;
            if (m == 0) core({2'h0, 16'h2000 | r[12:0]}, K_TRP, 1'b1, 1'b1, r[31:16]);
            core({2'h0, 16'hFA00 | {7'h0, r[8:0]}}, K_INT, 1'b0, 1'b1);
            nb = (m == 0) ? 2'h2 : m[1:0];
            apb(1'b1, `OFF_SCR, scr((m == 0) ? 2'h2 : ~m[1:0], 1'b0, 2'h0));
            ube_on = nb[1];
            seg_on = 1'b1;
            rd(`OFF_SCR, 1'b0, scr(nb, m == 0, 2'h0));
            a = {r[17:16], 16'h2000 | {2'h0, r[13:1], 1'b0}};
            w = r[31:16];
            b = r[25:18];
            core(a, K_ACK, 1'b1, 1'b1, w);
            core(a + 18'h1, K_ACK, 1'b1, 1'b0, {8'h0, b});
            core(a, K_ACK, 1'b0, 1'b1, 16'h0, {b, w[7:0]}, 16'hFFFF);
            core(a + 18'h1, K_ACK, 1'b0, 1'b0, 16'h0, {8'h0, b}, 16'h00FF);
            core(18'h00100, (m == 0) ? K_INT : K_ACK, 1'b0, 1'b1);
            apb(1'b1, `OFF_SCR, scr(nb, 1'b0, 2'h3));
            ube_on = 1'b0;
            seg_on = 1'b0;
            rd(`OFF_SCR, 1'b0, scr(nb, m == 0, 2'h3));
            check("port use", 35'({port0_bus_q, port1_bus_q, port4_bus_q}),
                  35'({1'b1, nb == 2'h3, 1'b0}));
            core(a, K_ACK, 1'b1, 1'b1, w);
        end
        rd(12'h00C, 1'b1, 32'h0);
        repeat (2) @(posedge pclk);
        summarize();
    end
endmodule // external_bus_mode_config_test
